// *** src/meter_ctl_pkg.sv ***
`default_nettype none
package meter_ctl_pkg;
   // ----------------------------------------
   // register map (byte offsets)
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SERCFG = 8'h04;
   localparam logic [7:0] OFS_LOCK = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_PEAK = 8'h18;
   localparam logic [7:0] OFS_VALLEY = 8'h1C;
   localparam logic [7:0] OFS_DISPLAY = 8'h20;
   localparam logic [7:0] OFS_CMD = 8'h24;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_SCOPE = 0;
   localparam int CTRL_PRINT_EN = 1;
   localparam int CTRL_ALM_RST_EN = 2;
   localparam int CTRL_LATCH_EN = 3;
   localparam int CTRL_FMT_LO = 4;
   localparam int SER_BAUD_LO = 0;
   localparam int SER_PAR_LO = 4;
   localparam int SER_STOP = 8;
   localparam int SER_ADDR_LO = 16;
   localparam int CMD_NVM = 0;
   localparam int CMD_EXIT = 1;
   localparam int IRQ_TARE = 0;
   localparam int IRQ_EXTRST = 1;
   localparam int IRQ_PRINT = 2;
   localparam int IRQ_ALMCLR = 3;
   localparam int IRQ_REJECT = 4;
   localparam int IRQ_W = 5;
   // ----------------------------------------
   // encodings and reset values
   // ----------------------------------------
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic STOP_ONE = 1'h0;
   localparam logic STOP_TWO = 1'h1;
   // baud codes 0..6 = 300,600,1200,2400,4800,9600,19200
   localparam logic [2:0] BAUD_300 = 3'h0;
   localparam logic [2:0] BAUD_9600 = 3'h5;
   localparam logic [2:0] BAUD_19200 = 3'h6;
   localparam logic [7:0] ADDR_RST = 8'h01;
   localparam logic [4:0] LOCK_RST = 5'h1F;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam int RDG_W = 24;
   localparam int NLINES = 7;
   // line indices
   localparam int LN_TARE = 0;
   localparam int LN_PEAK = 1;
   localparam int LN_VALLEY = 2;
   localparam int LN_EXTRST = 3;
   localparam int LN_HOLD = 4;
   localparam int LN_LOCK = 5;
   localparam int LN_PRINT = 6;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int DEBOUNCE_US = 5000;
   localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
   localparam int DBC_W = 20;
endpackage
`default_nettype wire

// *** src/line_debounce.sv ***
`default_nettype none
module line_debounce
   import meter_ctl_pkg::*;
#(
   parameter int unsigned CYC = DEBOUNCE_CYC
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [NLINES-1:0] raw_n,
   output logic [NLINES-1:0] clean_n_q
);
   // ----------------------------------------
   // per-line sync and debounce
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < NLINES; i++)
      begin : g_line
         logic meta_q;
         logic sync_q;
         logic [DBC_W-1:0] cnt_q;
         always_ff @(posedge core_clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               meta_q <= 1'h1;
               sync_q <= 1'h1;
               cnt_q <= '0;
               clean_n_q[i] <= 1'h1;
            end
            else
            begin
               meta_q <= raw_n[i];
               sync_q <= meta_q;
               if (sync_q == clean_n_q[i])
                  cnt_q <= '0;
               else if (cnt_q == DBC_W'(CYC - 1))
               begin
                  cnt_q <= '0;
                  clean_n_q[i] <= sync_q;
               end
               else
                  cnt_q <= cnt_q + DBC_W'(1);
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** src/extreme_track.sv ***
`default_nettype none
module extreme_track
   import meter_ctl_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic valid,
   input wire logic signed [RDG_W-1:0] value,
   output logic signed [RDG_W-1:0] peak_q,
   output logic signed [RDG_W-1:0] valley_q
);
   // ----------------------------------------
   // running highest and lowest reading
   // ----------------------------------------
   wire up = valid && (value > peak_q);
   wire dn = valid && (value < valley_q);
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         peak_q <= '0;
         valley_q <= '0;
      end
      else if (clear)
      begin
         peak_q <= value;
         valley_q <= value;
      end
      else
      begin
         if (up)
            peak_q <= value;
         if (dn)
            valley_q <= value;
      end
   end
endmodule
`default_nettype wire

// *** src/meter_external_control.sv ***
`default_nettype none
module meter_external_control
   import meter_ctl_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
)
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq_q,
   input wire logic tare_n,
   input wire logic peak_sel_n,
   input wire logic valley_sel_n,
   input wire logic ext_reset_n,
   input wire logic hold_n,
   input wire logic lockout_n,
   input wire logic print_reset_n,
   input wire logic menu_key,
   input wire logic live_valid,
   input wire logic signed [RDG_W-1:0] live_reading,
   input wire logic [1:0] setpoint_cond,
   input wire logic [1:0] alarm_cond,
   output logic signed [RDG_W-1:0] display_q,
   output logic display_flash_q,
   output logic signed [RDG_W-1:0] net_reading_q,
   output logic setup_mode_q,
   output logic hard_reset_q,
   output logic print_start_q,
   output logic [3:0] print_format_q,
   output logic nvm_store_q,
   output logic [2:0] baud_sel_q,
   output logic [1:0] parity_sel_q,
   output logic stop_sel_q,
   output logic [7:0] node_address_q,
   output logic [3:0] sp_pull_oe_q
);
   // ----------------------------------------
   // control lines
   // ----------------------------------------
   logic [NLINES-1:0] clean_n;
   logic [NLINES-1:0] prev_n_q;
   line_debounce #(.CYC(DEBOUNCE_CYCLES)) u_dbc (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .raw_n({print_reset_n, lockout_n, hold_n, ext_reset_n, valley_sel_n, peak_sel_n, tare_n}),
      .clean_n_q(clean_n)
   );
   wire [NLINES-1:0] act = ~clean_n;
   wire [NLINES-1:0] fall = prev_n_q & ~clean_n;
   wire tare_ev = fall[LN_TARE];
   wire extrst_ev = fall[LN_EXTRST];
   wire print_ev = fall[LN_PRINT];
   wire peak_act = act[LN_PEAK];
   wire valley_act = act[LN_VALLEY];
   wire hold_act = act[LN_HOLD];
   wire lock_act = act[LN_LOCK];

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] ctrl_q;
   logic [4:0] lockbits_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic signed [RDG_W-1:0] zero_ref_q;
   logic [1:0] alarm_lat_q;
   logic signed [RDG_W-1:0] peak_v;
   logic signed [RDG_W-1:0] valley_v;

   wire scope = ctrl_q[CTRL_SCOPE];
   wire full_rst = extrst_ev && !scope;
   wire pv_clear = extrst_ev || full_rst;
   wire print_go = print_ev && ctrl_q[CTRL_PRINT_EN];
   wire alm_clr = (print_ev && ctrl_q[CTRL_ALM_RST_EN]) || full_rst;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire req = (avs_read || avs_write) && avs_waitrequest;
   wire wr = avs_write && !avs_waitrequest;
   wire [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0] wdat = avs_writedata & bmask;
   wire sel_ctrl = avs_address == OFS_CTRL;
   wire sel_ser = avs_address == OFS_SERCFG;
   wire sel_lock = avs_address == OFS_LOCK;
   wire sel_stat = avs_address == OFS_IRQ_STAT;
   wire sel_mask = avs_address == OFS_IRQ_MASK;
   wire sel_cmd = avs_address == OFS_CMD;
   wire [31:0] ser_old = {8'h00, node_address_q, 7'h00, stop_sel_q,
                          2'h0, parity_sel_q, 1'h0, baud_sel_q};
   wire [31:0] ser_new = (ser_old & ~bmask) | wdat;
   wire [1:0] par_new = ser_new[SER_PAR_LO +: 2];
   wire [2:0] baud_new = ser_new[SER_BAUD_LO +: 3];
   wire ser_legal = (par_new != 2'h3) && (baud_new <= BAUD_19200);
   wire ser_ok = !lock_act && (lockbits_q == 5'h00) && ser_legal;
   wire cfg_ok = !lock_act;
   wire ctrl_we = wr && sel_ctrl && cfg_ok;
   wire ser_we = wr && sel_ser && ser_ok;
   wire lock_we = wr && sel_lock && cfg_ok;
   wire nvm_req = wr && sel_cmd && avs_byteenable[0] && avs_writedata[CMD_NVM];
   wire exit_req = wr && sel_cmd && avs_byteenable[0] && avs_writedata[CMD_EXIT];
   wire menu_refused = menu_key && !setup_mode_q && lock_act;
   wire reject = (wr && (sel_ctrl || sel_lock) && !cfg_ok) || (wr && sel_ser && !ser_ok)
                 || (nvm_req && lock_act) || menu_refused;
   wire [31:0] status_w = {18'h0, sp_pull_oe_q, alarm_lat_q, setup_mode_q, act};
   wire [31:0] rdata =
      sel_ctrl ? {24'h0, ctrl_q} :
      sel_ser ? ser_old :
      sel_lock ? {27'h0, lockbits_q} :
      (avs_address == OFS_STATUS) ? status_w :
      sel_stat ? {27'h0, irq_stat_q} :
      sel_mask ? {27'h0, irq_mask_q} :
      (avs_address == OFS_PEAK) ? {{8{peak_v[RDG_W-1]}}, peak_v} :
      (avs_address == OFS_VALLEY) ? {{8{valley_v[RDG_W-1]}}, valley_v} :
      (avs_address == OFS_DISPLAY) ? {{8{display_q[RDG_W-1]}}, display_q} :
      32'h0000_0000;

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         avs_waitrequest <= 1'h1;
         avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest <= !req;
         if (req && avs_read)
            avs_readdata <= rdata;
      end
   end

   // ----------------------------------------
   // configuration
   // ----------------------------------------
   wire [IRQ_W-1:0] events = {reject, alm_clr, print_go, extrst_ev, tare_ev};
   wire [IRQ_W-1:0] w1c = (wr && sel_stat && avs_byteenable[0]) ? avs_writedata[IRQ_W-1:0] : '0;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_q <= CTRL_RST;
         lockbits_q <= LOCK_RST;
         baud_sel_q <= BAUD_9600;
         parity_sel_q <= PAR_NONE;
         stop_sel_q <= STOP_ONE;
         node_address_q <= ADDR_RST;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         irq_q <= 1'h0;
      end
      else
      begin
         if (ctrl_we)
            ctrl_q <= (ctrl_q & ~bmask[7:0]) | wdat[7:0];
         if (lock_we)
            lockbits_q <= (lockbits_q & ~bmask[4:0]) | wdat[4:0];
         if (ser_we)
         begin
            baud_sel_q <= baud_new;
            parity_sel_q <= par_new;
            stop_sel_q <= ser_new[SER_STOP];
            node_address_q <= ser_new[SER_ADDR_LO +: 8];
         end
         if (wr && sel_mask && avs_byteenable[0])
            irq_mask_q <= avs_writedata[IRQ_W-1:0];
         irq_stat_q <= (irq_stat_q & ~w1c) | events;
         irq_q <= |(((irq_stat_q & ~w1c) | events) & irq_mask_q);
      end
   end

   // ----------------------------------------
   // reading path
   // ----------------------------------------
   wire signed [RDG_W-1:0] net_d = live_reading - zero_ref_q;
   extreme_track u_ext (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clear(pv_clear),
      .valid(live_valid),
      .value(net_d),
      .peak_q(peak_v),
      .valley_q(valley_v)
   );
   wire show_sel = peak_act || valley_act;
   wire signed [RDG_W-1:0] disp_src = peak_act ? peak_v : valley_act ? valley_v : net_d;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         zero_ref_q <= '0;
         net_reading_q <= '0;
         display_q <= '0;
         display_flash_q <= 1'h0;
      end
      else
      begin
         if (full_rst)
            zero_ref_q <= '0;
         else if (tare_ev)
            zero_ref_q <= live_reading;
         if (live_valid)
            net_reading_q <= net_d;
         if (!hold_act)
         begin
            display_q <= disp_src;
            display_flash_q <= show_sel;
         end
      end
   end

   // ----------------------------------------
   // modes, pulses, outputs
   // ----------------------------------------
   wire [1:0] alarm_d = (alm_clr ? 2'h0 : alarm_lat_q) | alarm_cond;
   wire [1:0] alarm_out = ctrl_q[CTRL_LATCH_EN] ? alarm_d : alarm_cond;
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prev_n_q <= '1;
         alarm_lat_q <= 2'h0;
         setup_mode_q <= 1'h0;
         hard_reset_q <= 1'h0;
         print_start_q <= 1'h0;
         print_format_q <= 4'h0;
         nvm_store_q <= 1'h0;
         sp_pull_oe_q <= 4'h0;
      end
      else
      begin
         prev_n_q <= clean_n;
         alarm_lat_q <= ctrl_q[CTRL_LATCH_EN] ? alarm_d : 2'h0;
         if (full_rst || exit_req)
            setup_mode_q <= 1'h0;
         else if (menu_key && !lock_act)
            setup_mode_q <= 1'h1;
         hard_reset_q <= full_rst;
         print_start_q <= print_go;
         if (print_go)
            print_format_q <= ctrl_q[CTRL_FMT_LO +: 4];
         nvm_store_q <= nvm_req && !lock_act;
         sp_pull_oe_q <= {alarm_out, setpoint_cond};
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   AST_TARE_CAPTURE: assert property (tare_ev && !full_rst |=> zero_ref_q == $past(live_reading))
      else $error("zero reference not captured on tare");
   AST_PEAK_SHOW: assert property (peak_act && !hold_act |=> display_q == $past(peak_v) && display_flash_q)
      else $error("peak not shown flashing");
   AST_VALLEY_SHOW: assert property (valley_act && !peak_act && !hold_act
      |=> display_q == $past(valley_v) && display_flash_q)
      else $error("valley not shown flashing");
   AST_EXTRST_SCOPE: assert property (extrst_ev |=> hard_reset_q == !$past(scope) && peak_v == valley_v)
      else $error("external reset scope wrong");
   AST_HOLD_FREEZE: assert property (hold_act ##1 hold_act |-> $stable(display_q))
      else $error("display moved during hold");
   AST_LOCK_CFG: assert property (lock_act && wr |=> $stable(ctrl_q) && $stable(lockbits_q)
      && !nvm_store_q && $stable(baud_sel_q))
      else $error("config changed under lockout");
   AST_PRINT_START: assert property (print_ev |=> print_start_q == $past(ctrl_q[CTRL_PRINT_EN]))
      else $error("print start wrong");
   AST_ALARM_CLEAR: assert property (alm_clr && alarm_cond == 2'h0 |=> alarm_lat_q == 2'h0)
      else $error("alarm latch not cleared");
   AST_PARITY_LEGAL: assert property (parity_sel_q != 2'h3 && baud_sel_q <= BAUD_19200)
      else $error("illegal serial code stored");
   AST_COMMS_LOCK: assert property (lockbits_q != 5'h00 |=> $stable(parity_sel_q) && $stable(stop_sel_q)
      && $stable(node_address_q))
      else $error("serial settings changed while locked");
   AST_SP_FOLLOW: assert property (!ctrl_q[CTRL_LATCH_EN] |=> sp_pull_oe_q == $past({alarm_cond, setpoint_cond}))
      else $error("setpoint outputs not following");
   AST_ONE_SHOT: assert property (tare_ev |=> !tare_ev [*2])
      else $error("tare acted twice");
   AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not single cycle");

   // ----------------------------------------
   // interrupt, bus and output checks
   // ----------------------------------------
   AST_IRQ_LEVEL: assert property ($stable(irq_mask_q) |-> irq_q == |(irq_stat_q & irq_mask_q))
      else $error("irq level wrong");
   AST_EVENT_STICKY: assert property (events != '0 |=> (irq_stat_q & $past(events)) == $past(events))
      else $error("event not latched");
   AST_W1C_CLEAR: assert property (wr && sel_stat && avs_byteenable[0] && events == '0
      |=> (irq_stat_q & $past(avs_writedata[IRQ_W-1:0])) == '0)
      else $error("status bit not cleared");
   AST_READ_DATA: assert property (avs_read && avs_waitrequest |=> avs_readdata == $past(rdata))
      else $error("read data wrong");
   AST_FULL_RESET: assert property (full_rst |=> zero_ref_q == '0 && !setup_mode_q)
      else $error("full reset incomplete");
   AST_NET_TRACK: assert property (live_valid |=> net_reading_q == $past(net_d))
      else $error("net reading not updated");
   AST_LIVE_SHOW: assert property (!peak_act && !valley_act && !hold_act
      |=> display_q == $past(net_d) && !display_flash_q)
      else $error("live reading not shown");
   AST_NVM_LOCK: assert property (lock_act |=> !nvm_store_q)
      else $error("storage under lockout");
   AST_MENU_LOCK: assert property (lock_act && !setup_mode_q |=> !setup_mode_q)
      else $error("setup entered under lockout");
   AST_PRINT_FMT: assert property (print_go |=> print_format_q == $past(ctrl_q[CTRL_FMT_LO +: 4]))
      else $error("print format not captured");
   AST_ALARM_KEEP: assert property (ctrl_q[CTRL_LATCH_EN] && !alm_clr
      |=> (alarm_lat_q & $past(alarm_lat_q)) == $past(alarm_lat_q))
      else $error("latched alarm lost");
   COV_TARE: cover property (tare_ev ##1 live_valid);
   COV_PEAK_HOLD: cover property (peak_act && hold_act);
   COV_PRINT: cover property (print_go ##1 print_start_q);
   COV_REJECT: cover property (reject ##1 irq_q);
endmodule
`default_nettype wire

// *** tb/ext_switches.sv ***
`default_nettype none
module ext_switches
   import meter_ctl_pkg::*;
(
   input wire logic core_clk,
   input wire logic [NLINES-1:0] press,
   output logic [NLINES-1:0] line_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 32'hC8A0;
   int cnt [NLINES];
   logic [NLINES-1:0] prev_q = '0;
   // ----------------------------------------
   // contacts to ground, bounce on each change
   // ----------------------------------------
   initial line_n = '1;
   always @(posedge core_clk)
   begin
      prev_q <= press;
      for (int i = 0; i < NLINES; i++)
      begin
         if (press[i] != prev_q[i])
            cnt[i] = 3;
         if (cnt[i] > 0)
         begin
            cnt[i] = cnt[i] - 1;
            line_n[i] <= 1'($random(seed));
         end
         else
            line_n[i] <= ~press[i];
      end
   end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench
   import meter_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, menu_key = 0, live_valid = 0;
   logic [7:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hF, print_format_q, sp_pull_oe_q;
   logic [1:0] setpoint_cond = '0, alarm_cond = '0, parity_sel_q;
   logic signed [RDG_W-1:0] live_reading = '0, display_q, net_reading_q, hi, lo, v, zr, r;
   logic avs_waitrequest, irq_q, display_flash_q, setup_mode_q, hard_reset_q, print_start_q;
   logic nvm_store_q, stop_sel_q;
   logic [2:0] baud_sel_q, b;
   logic [7:0] node_address_q, a;
   logic [NLINES-1:0] press = '0, ln;
   logic [31:0] sv, expq[$];
   int errors = 0, checked = 0, cyc = 0, seed = 32'hC8A0, n_hard = 0, n_prt = 0, n_nvm = 0;
   always #4 core_clk = ~core_clk;
   ext_switches ext_switches_inst (.core_clk, .press, .line_n(ln));
   meter_external_control #(.DEBOUNCE_CYCLES(4)) meter_external_control_inst (
      .core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .irq_q, .tare_n(ln[LN_TARE]), .peak_sel_n(ln[LN_PEAK]),
      .valley_sel_n(ln[LN_VALLEY]), .ext_reset_n(ln[LN_EXTRST]), .hold_n(ln[LN_HOLD]),
      .lockout_n(ln[LN_LOCK]), .print_reset_n(ln[LN_PRINT]), .menu_key, .live_valid, .live_reading,
      .setpoint_cond, .alarm_cond, .display_q, .display_flash_q, .net_reading_q, .setup_mode_q,
      .hard_reset_q, .print_start_q, .print_format_q, .nvm_store_q, .baud_sel_q, .parity_sel_q,
      .stop_sel_q, .node_address_q, .sp_pull_oe_q);
   // ----------------------------------------
   // checking and reporting
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cyc++;
      n_hard += (hard_reset_q === 1'b1);
      n_prt += (print_start_q === 1'b1);
      n_nvm += (nvm_store_q === 1'b1);
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      begin
         if (expq.size() == 0)
            check(avs_readdata, 32'hFFFF_FFFF);
         else
            check(avs_readdata, expq.pop_front());
      end
      if (cyc == 30000)
      begin
         errors++;
         results();
      end
   end
   // ----------------------------------------
   // bus, line and sample drivers
   // ----------------------------------------
   task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= adr;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      if (!wr)
         expq.push_back(d);
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] adr, input logic [31:0] e);
      bus(1'b0, adr, e);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      bus(1'b1, adr, d);
   endtask
   task automatic prs(input int ln_i, input logic on);
      press[ln_i] <= on;
      repeat (16) @(posedge core_clk);
   endtask
   task automatic smp(input logic signed [RDG_W-1:0] s);
      @(posedge core_clk);
      live_valid <= 1'b1;
      live_reading <= s;
      @(posedge core_clk);
      live_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic menu;
      @(posedge core_clk);
      menu_key <= 1'b1;
      @(posedge core_clk);
      menu_key <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(OFS_SERCFG, 32'h0001_0005);
      check(baud_sel_q, BAUD_9600);
      check(node_address_q, 8'h01);
      rd(OFS_LOCK, 32'h0000_001F);
      rd(8'hFC, 32'h0);
      wr(OFS_SERCFG, 32'h0007_0112);
      rd(OFS_SERCFG, 32'h0001_0005);
      rd(OFS_IRQ_STAT, 32'h10);
      wr(OFS_IRQ_STAT, 32'h10);
      wr(OFS_LOCK, 32'h0);
      for (int p = 0; p < 3; p++)
         for (int s = 0; s < 2; s++)
         begin
            b = 3'($unsigned($random(seed)) % 7);
            a = 8'($random(seed));
            sv = {8'h00, a, 7'h00, s[0], 2'h0, p[1:0], 1'b0, b};
            wr(OFS_SERCFG, sv);
            rd(OFS_SERCFG, sv);
            check(parity_sel_q, p[1:0]);
            check(stop_sel_q, s[0]);
            check(baud_sel_q, b);
         end
      wr(OFS_IRQ_MASK, 32'h1F);
      hi = 0;
      lo = 0;
      for (int i = 0; i < 6; i++)
      begin
         r = 24'(($unsigned($random(seed)) % 1000) + 1);
         v = i[0] ? r : -r;
         hi = (v > hi) ? v : hi;
         lo = (v < lo) ? v : lo;
         smp(v);
      end
      prs(LN_PEAK, 1);
      check(display_flash_q, 1'b1);
      check(display_q, hi);
      rd(OFS_STATUS, 32'h2);
      prs(LN_PEAK, 0);
      prs(LN_VALLEY, 1);
      check(display_flash_q, 1'b1);
      check(display_q, lo);
      prs(LN_VALLEY, 0);
      check(display_flash_q, 1'b0);
      prs(LN_HOLD, 1);
      smp(24'sd77);
      check(display_q, v);
      check(net_reading_q, 24'sd77);
      prs(LN_HOLD, 0);
      zr = 24'sd500;
      smp(zr);
      prs(LN_TARE, 1);
      repeat (30) @(posedge core_clk);
      prs(LN_TARE, 0);
      rd(OFS_IRQ_STAT, 32'h1);
      check(irq_q, 1'b1);
      smp(24'sd450);
      check(net_reading_q, -24'sd50);
      wr(OFS_IRQ_STAT, 32'h1);
      repeat (3) @(posedge core_clk);
      check(irq_q, 1'b0);
      wr(OFS_IRQ_MASK, 32'h0);
      prs(LN_TARE, 1);
      prs(LN_TARE, 0);
      check(irq_q, 1'b0);
      rd(OFS_IRQ_STAT, 32'h1);
      wr(OFS_IRQ_MASK, 32'h1F);
      repeat (3) @(posedge core_clk);
      check(irq_q, 1'b1);
      wr(OFS_IRQ_STAT, 32'h1F);
      wr(OFS_CTRL, 32'h1);
      smp(24'sd470);
      prs(LN_EXTRST, 1);
      rd(OFS_PEAK, 32'h14);
      rd(OFS_VALLEY, 32'h14);
      check(n_hard, 0);
      prs(LN_EXTRST, 0);
      wr(OFS_CTRL, 32'h0);
      prs(LN_EXTRST, 1);
      repeat (30) @(posedge core_clk);
      check(n_hard, 1);
      prs(LN_EXTRST, 0);
      rd(OFS_SERCFG, sv);
      wr(OFS_CTRL, 32'hA6);
      wr(OFS_IRQ_STAT, 32'h1F);
      prs(LN_PRINT, 1);
      repeat (30) @(posedge core_clk);
      check(n_prt, 1);
      check(print_format_q, 4'hA);
      rd(OFS_IRQ_STAT, 32'hC);
      prs(LN_PRINT, 0);
      wr(OFS_IRQ_STAT, 32'h1F);
      prs(LN_LOCK, 1);
      wr(OFS_CTRL, 32'h1);
      rd(OFS_CTRL, 32'hA6);
      wr(OFS_CMD, 32'h1);
      menu();
      check(n_nvm, 0);
      check(setup_mode_q, 1'b0);
      rd(OFS_IRQ_STAT, 32'h10);
      prs(LN_LOCK, 0);
      wr(OFS_CMD, 32'h1);
      menu();
      check(setup_mode_q, 1'b1);
      check(n_nvm, 1);
      wr(OFS_CMD, 32'h2);
      repeat (3) @(posedge core_clk);
      check(setup_mode_q, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         {alarm_cond, setpoint_cond} <= 4'($random(seed));
         repeat (4) @(posedge core_clk);
         check(sp_pull_oe_q, {alarm_cond, setpoint_cond});
      end
      {alarm_cond, setpoint_cond} <= 4'h4;
      wr(OFS_CTRL, 32'h0C);
      repeat (2) @(posedge core_clk);
      {alarm_cond, setpoint_cond} <= 4'h0;
      repeat (4) @(posedge core_clk);
      check(sp_pull_oe_q, 4'h4);
      prs(LN_PRINT, 1);
      check(sp_pull_oe_q, 4'h0);
      check(n_prt, 1);
      prs(LN_PRINT, 0);
      results();
   end
endmodule
`default_nettype wire
